// ===== inc/adc_cal_pkg.sv
package adc_cal_pkg;

  // data path widths
  localparam int WORD_BITS = 16;
  localparam int GAIN_FRAC_BITS = 14;
  localparam int ACC_BITS = 19;

  // one output word every 32 master clocks
  localparam logic [4:0] WORD_LAST = 5'h1f;
  localparam logic [4:0] WORD_FIRST = 5'h00;

  // hold-off after an align edge or after standby, in master clocks (2080)
  localparam logic [11:0] SYNC_HOLD_CYCLES = 12'h0820;

  // calibration timing, counted in output words
  localparam logic [7:0] SETTLE_WORDS_UNI = 8'h3c;
  localparam logic [7:0] SETTLE_WORDS_BI = 8'h60;
  localparam logic [7:0] AVG_WORDS = 8'h08;
  localparam logic [7:0] FINAL_SETTLE_WORDS = 8'h41;

  // gain factor is Q2.14; stored value is the deviation from unity
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam logic [15:0] GAIN_TARGET = 16'h7fff;
  localparam logic [15:0] GAIN_MAX = 16'h7fff;

  // values after reset
  localparam logic [15:0] OFFSET_CLEAR = 16'h0000;
  localparam logic [15:0] GAIN_DELTA_CLEAR = 16'h0000;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  typedef struct packed {
    logic standby;
    logic calibrate;
    logic input_range;
    logic pin_select;
  } ctrl_type;

  typedef struct packed {
    logic signed [15:0] offset;
    logic signed [15:0] gain_delta;
  } cal_store_type;

  typedef enum logic [1:0] {
    MOD_PINS,
    MOD_SHORTED,
    MOD_REFERENCE
  } mod_input_type;

endpackage : adc_cal_pkg

// ===== src/adc_calibration_sync_control.sv
`timescale 1ns/1ps
module adc_calibration_sync_control #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // interface mode and serial-mode control pins
  input wire logic serial_mode,
  input wire logic calibrate_pin,
  input wire logic low_power_hold,
  input wire logic input_range_select,
  input wire logic align_pin,
  // parallel-mode control register write
  input wire logic ctrl_write,
  input wire adc_cal_pkg::ctrl_type ctrl_wdata,
  // shared valid/align pin
  input wire logic valid_or_align_in,
  output logic valid_or_align_out,
  output logic valid_or_align_oe_n,
  // filter side
  input wire logic signed [WIDTH-1:0] filter_word,
  output logic filter_reset,
  output logic filter_run,
  output adc_cal_pkg::mod_input_type mod_input,
  // host data side
  output logic [WIDTH-1:0] result_word,
  output logic conversion_ready_flag,
  output logic calibrate_bit,
  output adc_cal_pkg::ctrl_type ctrl_status
);
  import adc_cal_pkg::*;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_STANDBY,
    ST_HOLD,
    ST_OFS_SETTLE,
    ST_OFS_AVG,
    ST_GAIN_SETTLE,
    ST_GAIN_AVG,
    ST_FINAL_SETTLE
  } state_type;

  function automatic logic in_cal(input state_type s);
    in_cal = (s == ST_OFS_SETTLE) || (s == ST_OFS_AVG) || (s == ST_GAIN_SETTLE) ||
             (s == ST_GAIN_AVG) || (s == ST_FINAL_SETTLE);
  endfunction : in_cal

  // words each calibration phase lasts; bipolar settles longer
  function automatic logic [7:0] phase_words(input state_type s, input logic bipolar);
    phase_words = FINAL_SETTLE_WORDS;
    if (s == ST_OFS_SETTLE || s == ST_GAIN_SETTLE) begin
      phase_words = bipolar ? SETTLE_WORDS_BI : SETTLE_WORDS_UNI;
    end else if (s == ST_OFS_AVG || s == ST_GAIN_AVG) begin
      phase_words = AVG_WORDS;
    end
  endfunction : phase_words

  state_type state;
  state_type next_state;
  ctrl_type ctrl;
  cal_store_type store;
  logic [4:0] word_phase;
  logic [11:0] hold_count;
  logic [7:0] word_count;
  logic signed [ACC_BITS-1:0] acc;
  logic signed [WIDTH-1:0] ofs_mean;
  logic signed [WIDTH-1:0] gain_diff;
  logic div_start;
  logic cal_bipolar;
  logic align_prev;
  logic calibrate_prev;
  logic [WIDTH-1:0] div_quotient;
  logic div_done;
  logic [WIDTH-1:0] corrected;

  // effective controls: pins in serial mode, register bits in parallel mode
  wire logic standby_now = serial_mode ? low_power_hold : ctrl.standby;
  wire logic bipolar_now = serial_mode ? input_range_select : ctrl.input_range;
  // shared pin counts as align only once released, so our own valid level is never a false edge
  wire logic align_level = serial_mode ? align_pin : (valid_or_align_oe_n & valid_or_align_in);
  // one flop stands in for the delayed-clock latch, so the host must move align mid-period
  wire logic align_rise = align_level & ~align_prev;
  wire logic cal_request = serial_mode ? (calibrate_pin & ~calibrate_prev) :
                                         (ctrl_write & ctrl_wdata.calibrate);
  wire logic word_tick = word_phase == WORD_LAST;
  wire logic phase_end = word_tick && (word_count == phase_words(state, cal_bipolar) - 8'h01);
  wire logic signed [ACC_BITS-1:0] acc_sum = acc + ACC_BITS'(filter_word);
  wire logic signed [WIDTH-1:0] avg_mean = acc_sum[ACC_BITS-1:3];
  wire logic cal_accept = cal_request && in_cal(next_state) && !in_cal(state);
  wire logic cal_exit = in_cal(state) && !in_cal(next_state);
  wire logic hold_now = next_state != ST_RUN;
  wire logic commit = div_done && state == ST_FINAL_SETTLE;
  wire logic strap_clear = serial_mode && !calibrate_pin;

  // standby beats align, align beats the running sequence
  always_comb begin
    next_state = state;
    if (standby_now) begin
      next_state = ST_STANDBY;
    end else if (align_rise) begin
      next_state = ST_HOLD;
    end else begin
      unique case (state)
        ST_STANDBY: begin
          next_state = ST_HOLD;
        end
        ST_HOLD: begin
          if (cal_request) begin
            next_state = ST_OFS_SETTLE;
          end else if (hold_count == 12'h000) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (cal_request) begin
            next_state = ST_OFS_SETTLE;
          end
        end
        ST_OFS_SETTLE: begin
          if (phase_end) begin
            next_state = ST_OFS_AVG;
          end
        end
        ST_OFS_AVG: begin
          if (phase_end) begin
            next_state = ST_GAIN_SETTLE;
          end
        end
        ST_GAIN_SETTLE: begin
          if (phase_end) begin
            next_state = ST_GAIN_AVG;
          end
        end
        ST_GAIN_AVG: begin
          if (phase_end) begin
            next_state = ST_FINAL_SETTLE;
          end
        end
        ST_FINAL_SETTLE: begin
          if (phase_end) begin
            next_state = ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // decimation phase moves only for align, never for calibration
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      word_phase <= WORD_FIRST;
    end else if (align_rise && !standby_now) begin
      word_phase <= WORD_FIRST;
    end else begin
      word_phase <= word_phase + 5'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_count <= SYNC_HOLD_CYCLES - 12'h001;
    end else if (next_state == ST_HOLD && state != ST_HOLD) begin
      hold_count <= SYNC_HOLD_CYCLES - 12'h001;
    end else if (hold_count != 12'h000) begin
      hold_count <= hold_count - 12'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || next_state != state) begin
      word_count <= 8'h00;
    end else if (word_tick) begin
      word_count <= word_count + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      align_prev <= 1'b0;
      // a calibrate pin left high through reset is not a start request
      calibrate_prev <= 1'b1;
    end else begin
      align_prev <= align_level;
      calibrate_prev <= calibrate_pin;
    end
  end

  // range is frozen at start; the values only suit that range
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cal_bipolar <= 1'b0;
    end else if (cal_accept) begin
      cal_bipolar <= bipolar_now;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || next_state != state) begin
      acc <= '0;
    end else if (word_tick && (state == ST_OFS_AVG || state == ST_GAIN_AVG)) begin
      acc <= acc_sum;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ofs_mean <= OFFSET_CLEAR;
      gain_diff <= OFFSET_CLEAR;
      div_start <= 1'b0;
    end else begin
      div_start <= phase_end && state == ST_GAIN_AVG && next_state == ST_FINAL_SETTLE;
      if (phase_end && state == ST_OFS_AVG) begin
        ofs_mean <= avg_mean;
      end
      if (phase_end && state == ST_GAIN_AVG) begin
        gain_diff <= avg_mean - ofs_mean;
      end
    end
  end

  gain_divider #(
    .WIDTH(WIDTH),
    .FRAC(GAIN_FRAC_BITS)
  ) u_gain_divider (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(div_start),
    .divisor(gain_diff),
    .quotient(div_quotient),
    .done(div_done)
  );

  // no reset except the power-up strap: values survive standby, sync and aborts
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      if (strap_clear) begin
        store.offset <= OFFSET_CLEAR;
        store.gain_delta <= GAIN_DELTA_CLEAR;
      end
    end else if (commit) begin
      store.offset <= ofs_mean;
      store.gain_delta <= div_quotient - GAIN_UNITY;
    end
  end

  // set wins over the end-of-calibration clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl <= CTRL_RESET;
      calibrate_bit <= 1'b0;
    end else begin
      calibrate_bit <= cal_accept | (calibrate_bit & ~cal_exit);
      if (ctrl_write && !serial_mode) begin
        ctrl.standby <= ctrl_wdata.standby;
        ctrl.input_range <= ctrl_wdata.input_range;
        ctrl.pin_select <= ctrl_wdata.pin_select;
      end
      ctrl.calibrate <= cal_accept | (ctrl.calibrate & ~cal_exit);
    end
  end

  output_corrector #(
    .WIDTH(WIDTH),
    .FRAC(GAIN_FRAC_BITS)
  ) u_output_corrector (
    .raw(filter_word),
    .offset(store.offset),
    .gain_delta(store.gain_delta),
    .bipolar(bipolar_now),
    .code(corrected)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      result_word <= '0;
      conversion_ready_flag <= 1'b0;
      valid_or_align_out <= 1'b0;
      valid_or_align_oe_n <= 1'b1;
      filter_reset <= 1'b0;
      filter_run <= 1'b0;
      mod_input <= MOD_PINS;
      ctrl_status <= CTRL_RESET;
    end else begin
      if (word_tick && !hold_now) begin
        result_word <= corrected;
      end
      if (hold_now) begin
        conversion_ready_flag <= !serial_mode;
      end else if (serial_mode) begin
        conversion_ready_flag <= word_tick;
      end else begin
        conversion_ready_flag <= word_tick || word_phase == WORD_FIRST;
      end
      valid_or_align_out <= !hold_now;
      valid_or_align_oe_n <= !serial_mode && ctrl.pin_select;
      filter_reset <= align_rise && !standby_now;
      filter_run <= !standby_now;
      ctrl_status <= {ctrl.standby, calibrate_bit, ctrl.input_range, ctrl.pin_select};
      unique case (next_state)
        ST_OFS_SETTLE, ST_OFS_AVG: begin
          mod_input <= MOD_SHORTED;
        end
        ST_GAIN_SETTLE, ST_GAIN_AVG: begin
          mod_input <= MOD_REFERENCE;
        end
        default: begin
          mod_input <= MOD_PINS;
        end
      endcase
    end
  end

endmodule : adc_calibration_sync_control

// ===== src/gain_divider.sv
`timescale 1ns/1ps
module gain_divider #(
  parameter int WIDTH = 16,
  parameter int FRAC = 14
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // request
  input wire logic start,
  input wire logic signed [WIDTH-1:0] divisor,
  // answer
  output logic [WIDTH-1:0] quotient,
  output logic done
);
  import adc_cal_pkg::*;

  localparam int STEPS = WIDTH + FRAC;

  logic [STEPS-1:0] dividend;
  logic [STEPS-1:0] quot;
  logic [WIDTH:0] rem;
  logic [WIDTH:0] den;
  logic [5:0] count;
  logic busy;
  logic bad;

  wire logic [WIDTH:0] trial = {rem[WIDTH-1:0], dividend[STEPS-1]};
  wire logic fits = trial >= den;
  wire logic [WIDTH:0] next_rem = fits ? trial - den : trial;
  wire logic last_step = busy && (count == 6'(STEPS - 1));
  wire logic [STEPS-1:0] final_quot = {quot[STEPS-2:0], fits};
  // saturate so a tiny reference reading cannot wrap the factor
  wire logic overflow = |final_quot[STEPS-1:WIDTH-1];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= 6'h00;
      rem <= '0;
      den <= '0;
      quot <= '0;
      dividend <= '0;
      bad <= 1'b0;
      quotient <= GAIN_UNITY;
    end else begin
      done <= last_step || (start && divisor <= 0);
      if (start) begin
        busy <= divisor > 0;
        bad <= divisor <= 0;
        count <= 6'h00;
        rem <= '0;
        quot <= '0;
        den <= {1'b0, divisor};
        dividend <= {GAIN_TARGET, {FRAC{1'b0}}};
        if (divisor <= 0) begin
          quotient <= GAIN_UNITY;
        end
      end else if (busy) begin
        count <= count + 6'h01;
        rem <= next_rem;
        quot <= final_quot;
        dividend <= {dividend[STEPS-2:0], 1'b0};
        if (last_step) begin
          busy <= 1'b0;
          quotient <= overflow ? GAIN_MAX : final_quot[WIDTH-1:0];
        end
      end
    end
  end

endmodule : gain_divider

// ===== src/output_corrector.sv
`timescale 1ns/1ps
module output_corrector #(
  parameter int WIDTH = 16,
  parameter int FRAC = 14
) (
  // raw filter word and calibration values
  input wire logic signed [WIDTH-1:0] raw,
  input wire logic signed [WIDTH-1:0] offset,
  input wire logic signed [WIDTH-1:0] gain_delta,
  input wire logic bipolar,
  // corrected, formatted code
  output logic [WIDTH-1:0] code
);
  import adc_cal_pkg::*;

  localparam logic signed [WIDTH:0] POS_LIMIT = {2'b00, {(WIDTH-1){1'b1}}};
  localparam logic signed [WIDTH:0] NEG_LIMIT = {2'b11, {(WIDTH-1){1'b0}}};

  wire logic signed [WIDTH:0] diff = WIDTH'(raw) - offset;
  // signed sum, so a factor below unity (negative delta) is sign-extended
  wire logic signed [WIDTH:0] gain = $signed({1'b0, GAIN_UNITY}) + gain_delta;
  wire logic signed [2*WIDTH+1:0] product = diff * gain;
  wire logic signed [2*WIDTH+1:0] scaled = product >>> FRAC;
  wire logic too_high = scaled > POS_LIMIT;
  wire logic too_low = scaled < NEG_LIMIT;
  wire logic [WIDTH-1:0] clipped = too_high ? POS_LIMIT[WIDTH-1:0] :
                                   too_low ? NEG_LIMIT[WIDTH-1:0] : scaled[WIDTH-1:0];

  // unipolar straight binary is the two's complement word with its sign flipped
  assign code = bipolar ? clipped : {~clipped[WIDTH-1], clipped[WIDTH-2:0]};

endmodule : output_corrector

// ===== testbench/adc_cal_chk.sv
`timescale 1ns/1ps
module adc_cal_chk
  import adc_cal_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // watched pins
  input wire logic serial_mode,
  input wire logic low_power_hold,
  input wire logic input_range_select,
  input wire logic filter_reset,
  input wire logic filter_run,
  input wire adc_cal_pkg::mod_input_type mod_input,
  input wire logic conversion_ready_flag,
  input wire logic calibrate_bit,
  input wire adc_cal_pkg::ctrl_type ctrl_status
);
  logic [13:0] cal_cnt;
  logic [11:0] hcnt;
  logic [5:0] gap;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  always_ff @(posedge mclk) begin
    if (sys_rst || !calibrate_bit) cal_cnt <= 14'h0000;
    else cal_cnt <= cal_cnt + 14'h0001;
  end

  // parks at the top once a hold-off intervenes, so only 31 or 63 are legal
  always_ff @(posedge mclk) begin
    if (sys_rst || conversion_ready_flag) gap <= 6'h00;
    else if (gap != 6'h3f) gap <= gap + 6'h01;
  end

  // serial only: the parallel hold level is high and clears it at once
  always_ff @(posedge mclk) begin
    if (sys_rst || conversion_ready_flag) hcnt <= 12'h000;
    else if (filter_reset) hcnt <= 12'h001;
    else if (hcnt != 12'h000) hcnt <= hcnt + 12'h001;
  end

  chk_cal_shorts: assert property (
    $rose(calibrate_bit) |-> mod_input == MOD_SHORTED)
    else $error("calibration did not short the inputs");
  chk_ref_follows: assert property (
    $rose(mod_input == MOD_REFERENCE) |-> $past(mod_input) == MOD_SHORTED && calibrate_bit)
    else $error("reference phase without offset phase");
  chk_pins_back: assert property (
    $fell(calibrate_bit) |-> mod_input == MOD_PINS)
    else $error("calibration ended off the input pins");
  chk_ready_held: assert property (
    calibrate_bit |-> conversion_ready_flag == !serial_mode)
    else $error("ready flag left hold level in calibration");
  chk_cal_bound: assert property (
    calibrate_bit |-> cal_cnt < ((serial_mode ? input_range_select : ctrl_status.input_range) ? 14'h2340 : 14'h1a40))
    else $error("calibration too long");
  chk_word_spacing: assert property (
    serial_mode && $rose(conversion_ready_flag) |-> (gap == 6'h1f || gap == 6'h3f) ##1 !conversion_ready_flag)
    else $error("serial word spacing wrong");
  chk_par_pulse: assert property (
    !serial_mode && $fell(conversion_ready_flag) |-> $past(conversion_ready_flag, 2))
    else $error("parallel ready pulse too short");
  chk_sync_hold: assert property (
    serial_mode && hcnt != 12'h000 |-> hcnt < 12'h0840 && (hcnt > 12'h0815 || !conversion_ready_flag))
    else $error("sync hold-off length wrong");
  chk_standby_stop: assert property (
    serial_mode && low_power_hold |=> !calibrate_bit && !filter_run)
    else $error("standby did not stop calibration");
  chk_sync_abort: assert property (
    filter_reset |-> !calibrate_bit)
    else $error("calibration survived an align edge");

  cov_cal_done: cover property ($fell(calibrate_bit) && mod_input == MOD_PINS);
  cov_sync: cover property (filter_reset);
  cov_par_word: cover property (!serial_mode && $fell(conversion_ready_flag));
endmodule : adc_cal_chk

bind adc_calibration_sync_control adc_cal_chk chk (
  .mclk(mclk), .sys_rst(sys_rst), .serial_mode(serial_mode), .low_power_hold(low_power_hold),
  .input_range_select(input_range_select),
  .filter_reset(filter_reset), .filter_run(filter_run), .mod_input(mod_input),
  .conversion_ready_flag(conversion_ready_flag), .calibrate_bit(calibrate_bit), .ctrl_status(ctrl_status));

// ===== testbench/adc_calibration_sync_control_tb.sv
`timescale 1ns/1ps
module adc_calibration_sync_control_tb;
  import adc_cal_pkg::*;
  logic mclk, sys_rst, serial_mode, calibrate_pin, low_power_hold, input_range_select, ctrl_write;
  logic go, al, pin, valid_or_align_out, valid_or_align_oe_n, filter_reset, filter_run;
  logic conversion_ready_flag, calibrate_bit, seen;
  logic [3:0] lowc;
  logic [15:0] result_word, pin_val, off_raw;
  logic signed [15:0] filter_word;
  ctrl_type ctrl_wdata, ctrl_status;
  mod_input_type mod_input;
  int failures, check_count, n, phr;
  time t0;

  // host drives the shared pin only while the block releases it
  assign pin = valid_or_align_oe_n ? al : valid_or_align_out;
  // reference sits 16'h4000 above offset, so the gain factor divides out to exactly 16'h7fff without saturating
  assign filter_word = mod_input == MOD_SHORTED ? off_raw : mod_input == MOD_REFERENCE ? 16'h3f00 : pin_val;

  adc_calibration_sync_control dut (.mclk(mclk), .sys_rst(sys_rst), .serial_mode(serial_mode),
    .calibrate_pin(calibrate_pin), .low_power_hold(low_power_hold), .input_range_select(input_range_select),
    .align_pin(al), .ctrl_write(ctrl_write), .ctrl_wdata(ctrl_wdata), .valid_or_align_in(pin),
    .valid_or_align_out(valid_or_align_out), .valid_or_align_oe_n(valid_or_align_oe_n),
    .filter_word(filter_word), .filter_reset(filter_reset), .filter_run(filter_run), .mod_input(mod_input),
    .result_word(result_word), .conversion_ready_flag(conversion_ready_flag), .calibrate_bit(calibrate_bit),
    .ctrl_status(ctrl_status));
  host_align_model host (.mclk(mclk), .go(go), .low_cycles(lowc), .align(al));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask : tick

  task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp

  task automatic cmpb(input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmpb

  task automatic word(input logic [15:0] exp);
    for (n = 0; n < 12000 && conversion_ready_flag !== 1'b0; n++) tick(1);
    if (n == 12000) failures++;
    for (n = 0; n < 12000 && conversion_ready_flag !== 1'b1; n++) tick(1);
    if (n == 12000) failures++;
    cmp(exp, result_word);
  endtask : word

  task automatic pin_cal;
    calibrate_pin = 1'b1;
    tick(1);
    calibrate_pin = 1'b0;
  endtask : pin_cal

  task automatic cal_wait;
    seen = 1'b0;
    for (n = 0; n < 12000 && calibrate_bit === 1'b1; n++) begin
      if (mod_input === MOD_REFERENCE) seen = 1'b1;
      tick(1);
    end
  endtask : cal_wait

  task automatic sync;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    for (n = 0; n < 100 && filter_reset !== 1'b1; n++) tick(1);
  endtask : sync

  task automatic hold_len;
    for (n = 0; n < 3000 && conversion_ready_flag === !serial_mode; n++) tick(1);
  endtask : hold_len

  task automatic wr(input ctrl_type v);
    ctrl_wdata = v;
    ctrl_write = 1'b1;
    tick(1);
    ctrl_write = 1'b0;
  endtask : wr

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // budget covers two full bipolar calibrations, one full unipolar calibration and five hold-offs
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    summarize();
  end

  initial begin
    failures = 0;
    check_count = 0;
    sys_rst = 1'b1;
    serial_mode = 1'b1;
    calibrate_pin = 1'b0;
    low_power_hold = 1'b0;
    input_range_select = 1'b1;
    ctrl_write = 1'b0;
    ctrl_wdata = 4'h0;
    go = 1'b0;
    lowc = 4'h1;
    pin_val = 16'h1234;
    off_raw = 16'hff00;
    tick(20);
    sys_rst = 1'b0;
    word(16'h1234);
    input_range_select = 1'b0;
    word(16'h9234);
    t0 = $time;
    phr = int'(($time / 50) % 32);
    word(16'h9234);
    cmp(16'h0020, 16'(($time - t0) / 50));
    $display("strap and word rate test done");
    input_range_select = 1'b1;
    pin_cal();
    cmpb(1'b1, calibrate_bit);
    cmp({14'h0000, mod_input}, {14'h0000, MOD_SHORTED});
    cal_wait();
    cmpb(1'b1, n < 9024);
    cmpb(1'b1, seen);
    pin_val = 16'h0f00;
    word(16'h1fff);
    cmp(16'(phr), 16'(($time / 50) % 32));
    pin_val = 16'hef00;
    word(16'he000);
    input_range_select = 1'b0;
    pin_cal();
    cal_wait();
    cmpb(1'b1, n < 6720);
    pin_val = 16'h0f00;
    word(16'h9fff);
    $display("serial calibration test done");
    lowc = 4'h6;
    sync();
    cmpb(1'b1, filter_reset);
    cmpb(1'b0, valid_or_align_out);
    hold_len();
    cmpb(1'b1, n > 2070 && n < 2090);
    word(16'h9fff);
    cmpb(1'b1, valid_or_align_out);
    off_raw = 16'h0000;
    pin_cal();
    tick(200);
    sync();
    cmpb(1'b0, calibrate_bit);
    off_raw = 16'hff00;
    word(16'h9fff);
    off_raw = 16'h0000;
    pin_cal();
    tick(100);
    low_power_hold = 1'b1;
    tick(2);
    cmpb(1'b0, calibrate_bit | filter_run);
    tick(50);
    low_power_hold = 1'b0;
    off_raw = 16'hff00;
    word(16'h9fff);
    $display("sync and abort test done");
    serial_mode = 1'b0;
    sys_rst = 1'b1;
    tick(20);
    sys_rst = 1'b0;
    wr(4'h2);
    tick(2);
    cmpb(1'b0, valid_or_align_oe_n);
    wr(4'h7);
    cmpb(1'b1, calibrate_bit & conversion_ready_flag);
    tick(2);
    cmpb(1'b1, valid_or_align_oe_n);
    cal_wait();
    cmpb(1'b1, n < 9024);
    // the status copy trails calibrate_bit by one clock
    tick(1);
    cmp({12'h000, ctrl_status}, 16'h0003);
    word(16'h1fff);
    sync();
    cmpb(1'b1, filter_reset);
    hold_len();
    cmpb(1'b1, n > 2070 && n < 2090);
    word(16'h1fff);
    $display("parallel mode test done");
    summarize();
  end
endmodule : adc_calibration_sync_control_tb

// ===== testbench/host_align_model.sv
`timescale 1ns/1ps
module host_align_model (
  // clock and request
  input wire logic mclk,
  input wire logic go,
  input wire logic [3:0] low_cycles,
  // align line to the device
  output logic align
);
  initial align = 1'b0;

  // low for low_cycles falling edges, then rise just after a falling edge
  always @(posedge go) begin
    align <= 1'b0;
    repeat (low_cycles) @(negedge mclk);
    align <= 1'b1;
    repeat (3) @(negedge mclk);
    align <= 1'b0;
  end
endmodule : host_align_model
